// ---- inc/dpwm_map.svh ----
// Register indices, field positions, reset values and prescaler counts of the dual PWM timer
// Summary of operation
// [RULE1] Two identical 8-bit timers, PWM or interval
// [RULE2] Prescaler gives fc/4, fc/16, fc/64 ticks
// [RULE3] Prescaler run bit starts; clear stops, zeroes
// [RULE4] Up-counter counts selected clock; reset selects PWM
// [RULE5] PWM clears at period top; timer at match
// [RULE6] Per-timer run bit counts or stops, clears
// [RULE7] Match whenever counter equals compare register
// [RULE8] Double-buffer enable per timer, reset cleared
// [RULE9] Buffer loads on overflow (PWM) or match
// [RULE10] Shared address; buffered write hits buffer only
// [RULE11] Software writes compare, then enables buffering
// [RULE12] Compare addresses adjacent; reads return buffer stage
// [RULE13] Interrupt select picks overflow or match source
// [RULE14] Timer mode match clears counter, toggles output
// [RULE15] Output flip-flop changes on match or overflow
// [RULE16] Mode register layout, bit 7 read-only state
// [RULE17] PWM polarity: set on match or on overflow
// [RULE18] Overflow action wins over simultaneous match
// [RULE19] Counting needs prescaler run and timer run
// [RULE20] Clock and period code 11 are reserved
`ifndef DPWM_MAP_SVH
`define DPWM_MAP_SVH

// Register indices, byte address is four times the index
`define DPWM_IDX_RUN      8'h20
`define DPWM_IDX_CMP0     8'h26
`define DPWM_IDX_CMP1     8'h27
`define DPWM_IDX_MODE0    8'h28
`define DPWM_IDX_MODE1    8'h29
`define DPWM_IDX_FFCTL    8'h2A

// Run control bit positions
`define DPWM_RUN_PRESC    7
`define DPWM_RUN_TMR0     2
`define DPWM_RUN_TMR1     3

// Flip-flop control field positions, four bits per timer
`define DPWM_FFCTL_W      4
`define DPWM_FFCTL_SW_LO  0
`define DPWM_FFCTL_TRG_LO 2

// Reset values
`define DPWM_RUN_RST      8'h00
`define DPWM_MODE_RST     7'h00
`define DPWM_CMP_RST      8'h00
`define DPWM_FFCTL_RST    8'h00
`define DPWM_FFCTL_SW_RD  2'h3

// Period tops for 2^n-1 with n of 6, 7 and 8
`define DPWM_TOP_N6       8'h3F
`define DPWM_TOP_N7       8'h7F
`define DPWM_TOP_N8       8'hFF

// Prescaler width and tick masks for fc/4, fc/16 and fc/64
`define DPWM_PRE_W        6
`define DPWM_DIV4_MASK    6'h03
`define DPWM_DIV16_MASK   6'h0F
`define DPWM_DIV64_MASK   6'h3F

`endif

// ---- inc/dpwm_pkg.sv ----
// Types shared by the dual PWM timer design files
package dpwm_pkg;

	// Input clock select codes
	typedef enum logic [1:0] {
		DPWM_CLK_DIV4  = 2'h0,
		DPWM_CLK_DIV16 = 2'h1,
		DPWM_CLK_DIV64 = 2'h2,
		DPWM_CLK_RSVD  = 2'h3
	} dpwm_clk_t;

	// Period select codes
	typedef enum logic [1:0] {
		DPWM_PER_N6   = 2'h0,
		DPWM_PER_N7   = 2'h1,
		DPWM_PER_N8   = 2'h2,
		DPWM_PER_RSVD = 2'h3
	} dpwm_per_t;

	// Hardware trigger of the output flip-flop
	typedef enum logic [1:0] {
		DPWM_TRG_OFF    = 2'h0,
		DPWM_TRG_INVERT = 2'h1,
		DPWM_TRG_SETMAT = 2'h2,
		DPWM_TRG_CLRMAT = 2'h3
	} dpwm_trg_t;

	// Software action on the output flip-flop
	typedef enum logic [1:0] {
		DPWM_SW_INVERT = 2'h0,
		DPWM_SW_SET    = 2'h1,
		DPWM_SW_CLEAR  = 2'h2,
		DPWM_SW_NONE   = 2'h3
	} dpwm_sw_t;

	// Writable part of a mode register, bits 6 down to 0
	typedef struct packed {
		logic      dbufEn;
		logic      irqSel;
		logic      modeBit;
		dpwm_clk_t clkSel;
		dpwm_per_t periodSel;
	} dpwm_mode_t;

	// Prescaler tick bundle
	typedef struct packed {
		logic div64;
		logic div16;
		logic div4;
	} dpwm_ticks_t;

endpackage : dpwm_pkg

// ---- hw/dpwm_prescaler.sv ----
// Shared prescaler producing the three timer clock ticks
`timescale 1ns/1ps
`include "dpwm_map.svh"
module dpwm_prescaler (
	input  wire logic          clk,
	input  wire logic          reset,
	input  wire logic          run,
	output dpwm_pkg::dpwm_ticks_t ticks
);
	logic [`DPWM_PRE_W-1:0] count_reg; // Free divider from fc
	dpwm_pkg::dpwm_ticks_t  ticks_reg; // Registered one-cycle ticks

	// Divider count, held at zero while stopped
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			count_reg <= '0; // see [RULE3]
		end else begin
			count_reg <= count_reg + 6'h01;
		end
	end

	// Tick when the low bits roll over: every 4, 16 and 64 clocks
	always_ff @(posedge clk) begin
		if (reset || !run) begin
			ticks_reg <= '0;
		end else begin
			ticks_reg.div4  <= (count_reg & `DPWM_DIV4_MASK) == `DPWM_DIV4_MASK; // see [RULE2]
			ticks_reg.div16 <= (count_reg & `DPWM_DIV16_MASK) == `DPWM_DIV16_MASK; // see [RULE2]
			ticks_reg.div64 <= count_reg == `DPWM_DIV64_MASK; // see [RULE2]
		end
	end

	assign ticks = ticks_reg;
endmodule : dpwm_prescaler

// ---- hw/dpwm_cmp_buffer.sv ----
// Compare register with its buffer stage sharing one address
`timescale 1ns/1ps
`include "dpwm_map.svh"
module dpwm_cmp_buffer (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       wrEn,
	input  wire logic [7:0] wrData,
	input  wire logic       dbufEn,
	input  wire logic       load,
	output logic      [7:0] cmpValue,
	output logic      [7:0] bufValue
);
	logic [7:0] cmp_reg; // Active compare value
	logic [7:0] buf_reg; // Buffer stage, readable

	// Buffer stage takes every write
	always_ff @(posedge clk) begin
		if (reset) begin
			buf_reg <= `DPWM_CMP_RST;
		end else if (wrEn) begin
			buf_reg <= wrData; // see [RULE10]
		end
	end

	// Active register: direct write when unbuffered, else reload event
	always_ff @(posedge clk) begin
		if (reset) begin
			cmp_reg <= `DPWM_CMP_RST;
		end else if (wrEn && !dbufEn) begin
			cmp_reg <= wrData; // see [RULE10]
		end else if (load && dbufEn) begin
			cmp_reg <= buf_reg; // see [RULE9]
		end
	end

	assign cmpValue = cmp_reg;
	assign bufValue = buf_reg;
endmodule : dpwm_cmp_buffer

// ---- hw/dpwm_top.sv ----
// Dual 8-bit PWM / interval timer with APB register access
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
`include "dpwm_map.svh"
module dpwm_top (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic             pwm0OutPin,
	output logic             pwm1OutPin,
	output logic             pwm0Irq,
	output logic             pwm1Irq
);
	localparam int NTMR = 2; // Number of timer channels

	// Bus side registers
	logic [31:0] prdata_reg;  // Read data, loaded as pready rises
	logic        pready_reg;  // One wait state then ready
	logic        pslverr_reg; // Error for unmapped index

	// Shared control registers
	logic [7:0]  run_reg;     // Prescaler and timer run bits
	logic [7:0]  ffctl_reg;   // Output trigger fields, software part reads as ones

	// Bus decode
	logic        accessPhase; // Access phase before ready
	logic        wrAcc;       // Write completes this edge
	logic [7:0]  regIdx;      // Register index from address
	logic        mapped;      // Index hits a register
	logic [31:0] rdMux;       // Read value for the index

	// Per-timer results gathered from the generate loop
	wire  [NTMR-1:0]   ffState;   // Output flip-flop values
	wire  [NTMR-1:0]   irqPulse;  // Registered interrupt pulses
	wire  [NTMR*8-1:0] bufFlat;   // Buffer stages for readback
	wire  [NTMR*7-1:0] modeFlat;  // Writable mode bits for readback

	// Prescaler ticks
	dpwm_pkg::dpwm_ticks_t ticks; // fc/4, fc/16, fc/64 pulses

	// Bus phase and index decode
	assign accessPhase = psel && penable && !pready_reg;
	assign wrAcc       = psel && penable && pready_reg && pwrite;
	assign regIdx      = paddr[9:2];

	// Index map check, upper address bits must be zero
	always_comb begin
		mapped = 1'b0;
		if (paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0) begin
			case (regIdx)
				`DPWM_IDX_RUN,
				`DPWM_IDX_CMP0,
				`DPWM_IDX_CMP1,
				`DPWM_IDX_MODE0,
				`DPWM_IDX_MODE1,
				`DPWM_IDX_FFCTL: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	end

	// Read value per index, unmapped reads zero
	always_comb begin
		rdMux = 32'h0000_0000;
		if (mapped) begin
			case (regIdx)
				`DPWM_IDX_RUN: begin
					rdMux = {24'h00_0000, run_reg};
				end
				`DPWM_IDX_CMP0: begin
					rdMux = {24'h00_0000, bufFlat[7:0]}; // see [RULE12]
				end
				`DPWM_IDX_CMP1: begin
					rdMux = {24'h00_0000, bufFlat[15:8]}; // see [RULE12]
				end
				`DPWM_IDX_MODE0: begin
					rdMux = {24'h00_0000, ffState[0], modeFlat[6:0]}; // see [RULE16]
				end
				`DPWM_IDX_MODE1: begin
					rdMux = {24'h00_0000, ffState[1], modeFlat[13:7]}; // see [RULE16]
				end
				`DPWM_IDX_FFCTL: begin
					rdMux = {24'h00_0000, ffctl_reg[7:6], `DPWM_FFCTL_SW_RD,
						ffctl_reg[3:2], `DPWM_FFCTL_SW_RD};
				end
				default: begin
					rdMux = 32'h0000_0000;
				end
			endcase
		end
	end

	// Ready rises one cycle into the access phase, drops after
	always_ff @(posedge clk) begin
		if (reset) begin
			pready_reg <= 1'b0;
		end else begin
			pready_reg <= accessPhase;
		end
	end

	// Read data and error captured with ready
	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (accessPhase) begin
			prdata_reg  <= pwrite ? 32'h0000_0000 : rdMux;
			pslverr_reg <= !mapped;
		end else begin
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end
	end

	// Run control register
	always_ff @(posedge clk) begin
		if (reset) begin
			run_reg <= `DPWM_RUN_RST; // see [RULE3] [RULE6]
		end else if (wrAcc && mapped && regIdx == `DPWM_IDX_RUN) begin
			// Only the defined run bits are kept
			run_reg <= 8'h00;
			run_reg[`DPWM_RUN_PRESC] <= pwdata[`DPWM_RUN_PRESC]; // see [RULE3]
			run_reg[`DPWM_RUN_TMR0]  <= pwdata[`DPWM_RUN_TMR0]; // see [RULE6]
			run_reg[`DPWM_RUN_TMR1]  <= pwdata[`DPWM_RUN_TMR1]; // see [RULE6]
		end
	end

	// Flip-flop control register, trigger fields only
	always_ff @(posedge clk) begin
		if (reset) begin
			ffctl_reg <= `DPWM_FFCTL_RST;
		end else if (wrAcc && mapped && regIdx == `DPWM_IDX_FFCTL) begin
			ffctl_reg <= {pwdata[7:6], 2'h0, pwdata[3:2], 2'h0};
		end
	end

	// Shared prescaler
	dpwm_prescaler u_prescaler (
		.clk   (clk),
		.reset (reset),
		.run   (run_reg[`DPWM_RUN_PRESC]),
		.ticks (ticks)
	);

	// Two identical timer channels
	for (genvar i = 0; i < NTMR; i++) begin : g_tmr // see [RULE1]
		localparam logic [7:0] CMP_IDX  = (i == 0) ? `DPWM_IDX_CMP0 : `DPWM_IDX_CMP1;
		localparam logic [7:0] MODE_IDX = (i == 0) ? `DPWM_IDX_MODE0 : `DPWM_IDX_MODE1;
		localparam int         RUN_BIT  = (i == 0) ? `DPWM_RUN_TMR0 : `DPWM_RUN_TMR1;
		localparam int         FF_LO    = i * `DPWM_FFCTL_W;

		dpwm_pkg::dpwm_mode_t mode_reg;  // Writable mode bits
		logic [7:0]           count_reg; // Up-counter
		logic                 ff_reg;    // Output flip-flop
		logic                 irq_reg;   // Interrupt pulse
		logic                 tick;      // Selected clock tick gated by run bits
		logic                 timerRun;  // Own run bit
		logic [7:0]           top;       // PWM period top
		logic [7:0]           cmpValue;  // Active compare value
		logic [7:0]           bufValue;  // Buffer stage
		logic                 matchNow;  // Counter equals compare
		logic                 matchEv;   // Match on a counting tick
		logic                 ovfEv;     // Period overflow on a counting tick
		logic                 reload;    // Buffer-to-compare transfer
		logic                 swWr;      // Software flip-flop action written
		dpwm_pkg::dpwm_sw_t   swAct;     // Written software action
		dpwm_pkg::dpwm_trg_t  trg;       // Hardware trigger mode

		assign timerRun = run_reg[RUN_BIT];
		assign trg      = dpwm_pkg::dpwm_trg_t'(ffctl_reg[FF_LO+`DPWM_FFCTL_TRG_LO +: 2]);
		assign swAct    = dpwm_pkg::dpwm_sw_t'(pwdata[FF_LO+`DPWM_FFCTL_SW_LO +: 2]);
		assign swWr     = wrAcc && mapped && regIdx == `DPWM_IDX_FFCTL && swAct != dpwm_pkg::DPWM_SW_NONE;

		// Mode register, bit 7 is the live flip-flop state
		always_ff @(posedge clk) begin
			if (reset) begin
				mode_reg <= dpwm_pkg::dpwm_mode_t'(`DPWM_MODE_RST); // see [RULE4] [RULE8]
			end else if (wrAcc && mapped && regIdx == MODE_IDX) begin
				mode_reg <= dpwm_pkg::dpwm_mode_t'(pwdata[6:0]); // see [RULE16]
			end
		end

		// Clock select, reserved code never ticks
		always_comb begin
			case (mode_reg.clkSel)
				dpwm_pkg::DPWM_CLK_DIV4:  tick = ticks.div4; // see [RULE2]
				dpwm_pkg::DPWM_CLK_DIV16: tick = ticks.div16; // see [RULE2]
				dpwm_pkg::DPWM_CLK_DIV64: tick = ticks.div64; // see [RULE2]
				default:                  tick = 1'b0; // see [RULE20]
			endcase
			tick = tick && run_reg[`DPWM_RUN_PRESC] && timerRun; // see [RULE19]
		end

		// Period top, reserved code uses the full 8-bit top
		always_comb begin
			case (mode_reg.periodSel)
				dpwm_pkg::DPWM_PER_N6: top = `DPWM_TOP_N6;
				dpwm_pkg::DPWM_PER_N7: top = `DPWM_TOP_N7;
				dpwm_pkg::DPWM_PER_N8: top = `DPWM_TOP_N8;
				default:               top = `DPWM_TOP_N8; // see [RULE20]
			endcase
		end

		// Match and overflow events
		assign matchNow = count_reg == cmpValue; // see [RULE7]
		assign matchEv  = tick && matchNow;
		assign ovfEv    = tick && (mode_reg.modeBit ? count_reg == `DPWM_TOP_N8 : count_reg == top); // see [RULE5]
		assign reload   = mode_reg.modeBit ? matchEv : ovfEv; // see [RULE9]

		// Up-counter: cleared when stopped, by overflow in PWM, by match in timer mode
		always_ff @(posedge clk) begin
			if (reset || !timerRun) begin
				count_reg <= 8'h00; // see [RULE6]
			end else if (tick) begin
				if (!mode_reg.modeBit && ovfEv) begin
					count_reg <= 8'h00; // see [RULE5]
				end else if (mode_reg.modeBit && matchEv) begin
					count_reg <= 8'h00; // see [RULE14]
				end else begin
					count_reg <= count_reg + 8'h01; // see [RULE4]
				end
			end
		end

		// Compare register with buffer stage
		dpwm_cmp_buffer u_cmp (
			.clk      (clk),
			.reset    (reset),
			.wrEn     (wrAcc && mapped && regIdx == CMP_IDX),
			.wrData   (pwdata[7:0]),
			.dbufEn   (mode_reg.dbufEn),
			.load     (reload),
			.cmpValue (cmpValue),
			.bufValue (bufValue)
		);

		// Interrupt source select, one-cycle pulse
		always_ff @(posedge clk) begin
			if (reset) begin
				irq_reg <= 1'b0;
			end else begin
				irq_reg <= mode_reg.irqSel ? matchEv : ovfEv; // see [RULE13]
			end
		end

		// Output flip-flop: software action first, then hardware events
		always_ff @(posedge clk) begin
			if (reset) begin
				ff_reg <= 1'b0;
			end else if (swWr) begin
				case (swAct)
					dpwm_pkg::DPWM_SW_INVERT: ff_reg <= !ff_reg;
					dpwm_pkg::DPWM_SW_SET:    ff_reg <= 1'b1;
					dpwm_pkg::DPWM_SW_CLEAR:  ff_reg <= 1'b0;
					default:                  ff_reg <= ff_reg;
				endcase
			end else if (mode_reg.modeBit) begin
				// Timer mode: match toggles when a trigger is enabled
				if (matchEv && trg != dpwm_pkg::DPWM_TRG_OFF) begin
					ff_reg <= !ff_reg; // see [RULE14] [RULE15]
				end
			end else if (ovfEv) begin
				// PWM overflow, takes priority over a same-tick match
				case (trg)
					dpwm_pkg::DPWM_TRG_INVERT: ff_reg <= !ff_reg; // see [RULE18]
					dpwm_pkg::DPWM_TRG_SETMAT: ff_reg <= 1'b0; // see [RULE17] [RULE18]
					dpwm_pkg::DPWM_TRG_CLRMAT: ff_reg <= 1'b1; // see [RULE17] [RULE18]
					default:                   ff_reg <= ff_reg;
				endcase
			end else if (matchEv) begin
				// PWM match
				case (trg)
					dpwm_pkg::DPWM_TRG_INVERT: ff_reg <= !ff_reg; // see [RULE15]
					dpwm_pkg::DPWM_TRG_SETMAT: ff_reg <= 1'b1; // see [RULE17]
					dpwm_pkg::DPWM_TRG_CLRMAT: ff_reg <= 1'b0; // see [RULE17]
					default:                   ff_reg <= ff_reg;
				endcase
			end
		end

		// Gather per-timer results
		assign ffState[i]          = ff_reg;
		assign irqPulse[i]         = irq_reg;
		assign bufFlat[i*8 +: 8]   = bufValue;
		assign modeFlat[i*7 +: 7]  = mode_reg;
	end

	// Outputs, all from flip-flops
	assign prdata     = prdata_reg;
	assign pready     = pready_reg;
	assign pslverr    = pslverr_reg;
	assign pwm0OutPin = ffState[0]; // see [RULE15]
	assign pwm1OutPin = ffState[1]; // see [RULE15]
	assign pwm0Irq    = irqPulse[0];
	assign pwm1Irq    = irqPulse[1];
endmodule : dpwm_top

// ---- tb/dpwm_sva.sv ----
// Port-level assertions for the dual PWM timer
`timescale 1ns/1ps
`include "dpwm_map.svh"
module dpwm_sva (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        pwm0OutPin,
	input wire logic        pwm1OutPin,
	input wire logic        pwm0Irq,
	input wire logic        pwm1Irq
);
	localparam logic [11:0] A_RUN = {2'h0, `DPWM_IDX_RUN, 2'h0};
	localparam logic [11:0] A_FF  = {2'h0, `DPWM_IDX_FFCTL, 2'h0};

	logic [7:0] runReg; // Shadow of run control
	logic       wrDone; // Write completes this edge
	logic       ffWr;   // Flip-flop control write
	logic       run0;   // Timer 0 may count
	logic       run1;   // Timer 1 may count
	logic       mapped; // Address hits a register

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	assign wrDone = psel && penable && pready && pwrite;
	assign ffWr   = wrDone && (paddr == A_FF);
	assign run0   = runReg[`DPWM_RUN_PRESC] && runReg[`DPWM_RUN_TMR0];
	assign run1   = runReg[`DPWM_RUN_PRESC] && runReg[`DPWM_RUN_TMR1];
	assign mapped = paddr inside {A_RUN, A_FF, {2'h0, `DPWM_IDX_CMP0, 2'h0}, {2'h0, `DPWM_IDX_CMP1, 2'h0},
		{2'h0, `DPWM_IDX_MODE0, 2'h0}, {2'h0, `DPWM_IDX_MODE1, 2'h0}};

	// Follow run control writes
	always_ff @(posedge clk) begin
		if (reset) begin
			runReg <= 8'h00;
		end else if (wrDone && (paddr == A_RUN)) begin
			runReg <= pwdata[7:0];
		end
	end

	a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not in second access cycle");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_unmapped_err: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (pready && mapped |-> !pslverr && prdata[31:8] == 24'h0)
		else $error("mapped access flagged or wide data");
	a_irq_pulse: assert property (pwm0Irq || pwm1Irq |=> !pwm0Irq && !pwm1Irq)
		else $error("interrupt longer than one cycle");
	a_idle_irq0: assert property (!run0 && !$past(run0, 2) |-> !pwm0Irq)
		else $error("timer 0 interrupt while stopped");
	a_idle_irq1: assert property (!run1 && !$past(run1, 2) |-> !pwm1Irq)
		else $error("timer 1 interrupt while stopped");
	a_pin_hold: assert property (!run0 && !$past(run0) && !$past(ffWr) |-> $stable(pwm0OutPin))
		else $error("timer 0 pin moved while stopped");
	a_reset_quiet: assert property (disable iff (1'b0) $past(reset) |->
		!pready && !pwm0Irq && !pwm1Irq && !pwm0OutPin && !pwm1OutPin)
		else $error("outputs not cleared by reset");

	c_irq0: cover property (pwm0Irq);
	c_irq1: cover property (pwm1Irq);
	c_err: cover property (pready && pslverr);
	c_pin_rise: cover property ($rose(pwm0OutPin));
endmodule : dpwm_sva

// ---- tb/dual_8bit_pwm_interval_timer_tb.sv ----
// Self-checking bench for the dual PWM timer
`timescale 1ns/1ps
`include "dpwm_map.svh"
module dual_8bit_pwm_interval_timer_tb;
	localparam logic [11:0] A_RUN   = {2'h0, `DPWM_IDX_RUN, 2'h0};
	localparam logic [11:0] A_CMP0  = {2'h0, `DPWM_IDX_CMP0, 2'h0};
	localparam logic [11:0] A_CMP1  = {2'h0, `DPWM_IDX_CMP1, 2'h0};
	localparam logic [11:0] A_MODE0 = {2'h0, `DPWM_IDX_MODE0, 2'h0};
	localparam logic [11:0] A_MODE1 = {2'h0, `DPWM_IDX_MODE1, 2'h0};
	localparam logic [11:0] A_FF    = {2'h0, `DPWM_IDX_FFCTL, 2'h0};

	logic        clk;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        pwm0OutPin;
	logic        pwm1OutPin;
	logic        pwm0Irq;
	logic        pwm1Irq;
	logic [1:0]  pins;      // Both output pins
	int          errorCnt;  // Mismatches seen
	int          numChecks; // Comparisons made

	assign pins = {pwm1OutPin, pwm0OutPin};

	dpwm_top u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm0OutPin(pwm0OutPin), .pwm1OutPin(pwm1OutPin), .pwm0Irq(pwm0Irq), .pwm1Irq(pwm1Irq));

	// Free-running 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic finishTest();
		if (errorCnt == 0 && numChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : finishTest

	// Value comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer, waits for pready
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			errorCnt++;
			$display("BAD %0t: no pready", $time);
			finishTest();
		end else begin
			rd = prdata;
			err = pslverr;
			psel    <= 1'b0;
			penable <= 1'b0;
		end
	endtask : xfer

	// Register write, must not be refused
	task automatic wr(input logic [11:0] a, input logic [31:0] wd);
		logic [31:0] d;
		logic        e;
		xfer(1'b1, a, wd, d, e);
		chk({31'h0, e}, 32'h0);
	endtask : wr

	// Register read against expected value
	task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic        e;
		xfer(1'b0, a, 32'h0, d, e);
		chk(d, exp);
		chk({31'h0, e}, 32'h0);
	endtask : rdChk

	// Length of the next span of a pin at a level
	task automatic gapTo(input int sel, input logic lvl, output logic [31:0] n);
		int k;
		k = 0;
		n = 0;
		while (pins[sel] !== lvl && k < 3000) begin
			@(posedge clk);
			#1;
			k++;
		end
		while (pins[sel] === lvl && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (k >= 3000 || n >= 3000) begin
			errorCnt++;
			$display("BAD %0t: pin wait ran out", $time);
			finishTest();
		end
	endtask : gapTo

	// Pin must keep a level for a number of cycles
	task automatic hold(input int sel, input logic lvl, input int cycles);
		logic bad;
		bad = 1'b0;
		for (int i = 0; i < cycles; i++) begin
			@(posedge clk);
			#1;
			bad = bad | (pins[sel] !== lvl);
		end
		chk({31'h0, bad}, 32'h0);
	endtask : hold

	// Main sequence
	initial begin
		logic [31:0] d;
		logic        e;
		logic [31:0] n;
		logic [31:0] m;
		logic        lv;
		reset   = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0;
		errorCnt  = 0;
		numChecks = 0;
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		// Reset values and refused access
		rdChk(A_RUN, 32'h00);
		rdChk(A_MODE0, 32'h00);
		rdChk(A_MODE1, 32'h00);
		rdChk(A_CMP1, 32'h00);
		rdChk(A_FF, 32'h33);
		xfer(1'b0, 12'h084, 32'h0, d, e);
		chk({31'h0, e}, 32'h1);
		chk(d, 32'h0);
		wr(A_MODE1, 32'hFF);
		rdChk(A_MODE1, 32'h7F);
		// PWM, set on match, clear on overflow, buffered reload
		wr(A_FF, 32'h3A);
		wr(A_CMP0, 32'h10);
		rdChk(A_CMP0, 32'h10);
		wr(A_MODE0, 32'h40);
		wr(A_CMP0, 32'h20);
		rdChk(A_CMP0, 32'h20);
		wr(A_RUN, 32'h84);
		gapTo(0, 1'b1, n);
		chk(n, 32'hBC);
		// Interrupt pulse stands only in the cycle of the overflow edge
		chk({31'h0, pwm0Irq}, 32'h1);
		gapTo(0, 1'b1, n);
		chk(n, 32'h7C);
		gapTo(0, 1'b0, n);
		chk(n, 32'h84);
		// Compare at top: overflow wins, 0 and 100 percent
		wr(A_MODE0, 32'h00);
		wr(A_CMP0, 32'h3F);
		for (int t = 0; t < 2; t++) begin
			wr(A_FF, (t != 0) ? 32'h3E : 32'h3A);
			repeat (300) @(posedge clk);
			hold(0, t[0], 600);
		end
		// Interval timer on timer 1 across clock selects, compare written unbuffered
		wr(A_MODE1, 32'h30);
		wr(A_CMP1, 32'h06);
		rdChk(A_CMP1, 32'h06);
		wr(A_FF, 32'h6B);
		for (int k = 0; k < 3; k++) begin
			wr(A_RUN, 32'h84);
			wr(A_MODE1, 32'h30 | (k << 2));
			wr(A_RUN, 32'h8C);
			gapTo(1, 1'b1, n);
			gapTo(1, 1'b0, n);
			chk(n, 32'h7 << (2 * k + 2));
			chk({31'h0, pwm1Irq}, 32'h1);
		end
		// Timer stop, then prescaler stop: pins freeze
		for (int s = 0; s < 2; s++) begin
			wr(A_RUN, (s != 0) ? 32'h0C : 32'h80);
			@(posedge clk);
			#1;
			lv = pins[0];
			hold(0, lv, 300);
			lv = pins[1];
			hold(1, lv, 300);
		end
		// PWM periods of 128 and 256 ticks, invert on match and overflow
		for (int p = 1; p < 3; p++) begin
			wr(A_RUN, 32'h80);
			wr(A_MODE0, p);
			wr(A_FF, 32'h36);
			wr(A_RUN, 32'h84);
			gapTo(0, 1'b1, n);
			gapTo(0, 1'b0, m);
			chk(n + m, 32'h100 << p);
		end
		// Software set and invert of a stopped timer's pin, state readback
		wr(A_RUN, 32'h00);
		wr(A_FF, 32'h31);
		#1;
		chk({31'h0, pins[0]}, 32'h1);
		rdChk(A_MODE0, 32'h82);
		wr(A_FF, 32'h30);
		#1;
		chk({31'h0, pins[0]}, 32'h0);
		finishTest();
	end
endmodule : dual_8bit_pwm_interval_timer_tb

bind dpwm_top dpwm_sva u_sva (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pwm0OutPin(pwm0OutPin), .pwm1OutPin(pwm1OutPin), .pwm0Irq(pwm0Irq), .pwm1Irq(pwm1Irq));
